// ---- src/dacdc_pkg.sv ----
// Constants for the two-channel converter control block
package dacdc_pkg;
    localparam int DATA_W = 12;
    localparam logic [11:0] ADDR_CTL = 12'h000;
    localparam logic [11:0] ADDR_SWT = 12'h004;
    localparam logic [11:0] ADDR_R12_0 = 12'h008;
    localparam logic [11:0] ADDR_L12_0 = 12'h00C;
    localparam logic [11:0] ADDR_R8_0 = 12'h010;
    localparam logic [11:0] ADDR_R12_1 = 12'h014;
    localparam logic [11:0] ADDR_L12_1 = 12'h018;
    localparam logic [11:0] ADDR_R8_1 = 12'h01C;
    localparam logic [11:0] ADDR_DR12 = 12'h020;
    localparam logic [11:0] ADDR_DL12 = 12'h024;
    localparam logic [11:0] ADDR_DR8 = 12'h028;
    localparam logic [11:0] ADDR_DO0 = 12'h02C;
    localparam logic [11:0] ADDR_DO1 = 12'h030;
    localparam logic [11:0] ADDR_DUAL = 12'h034;
    localparam int CH1_SHIFT = 16;
    localparam int F_ON = 0;
    localparam int F_BOFF = 1;
    localparam int F_TEN = 2;
    localparam int F_TSEL = 3;
    localparam int F_NKIND = 6;
    localparam int F_NWID = 8;
    localparam int F_DMA = 12;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTL_MASK = 32'h1FFF_1FFF;
    localparam logic [2:0] SEL_SOFT = 3'h7;
    localparam logic [2:0] SEL_LINE9 = 3'h6;
    localparam logic [11:0] LFSR_SEED = 12'hAAA;
    localparam logic [1:0] NOISE_NONE = 2'h0;
    localparam logic [1:0] NOISE_LFSR = 2'h1;
    localparam logic [3:0] NWID_MAX = 4'hB;
endpackage

// ---- src/dacdc_control.sv ----
// Digital control of a two-channel 12-bit converter, APB slave
// Overview of operation
// R01 - Channel active only while its on bit set
// R02 - Buffer on after reset until off bit
// R03 - 8/12-bit, left/right data into 12-bit hold
// R04 - 8-bit write zeroes low four hold bits
// R05 - Start by software or trigger rising edge
// R06 - Three-bit select picks timer, line9, software
// R07 - Soft trigger bit triggers when software selected
// R08 - Triggered: copy hold to output on event
// R09 - Untriggered: copy hold after each update
// R10 - Noise kind: none, LFSR, triangle
// R11 - Noise only with external trigger enabled
// R12 - Noise width is field plus one, max twelve
// R13 - LFSR mode adds noise at transfer
// R14 - LFSR noise masked to width low bits
// R15 - Triangle ramps zero to width limit
// R16 - DMA only with trigger and DMA enables
// R17 - DMA request on hardware triggers only
// R18 - Concurrent writes update both channels together
// R19 - Three dual registers load both holds
// R20 - Software sets identical triggers for concurrency
// R21 - Software sets at least one DMA enable
// R22 - Each channel keeps own noise settings
// R23 - Software puts pins in analog first
// R24 - Field positions of the three data forms
// R25 - Soft trigger bit self-clears after transfer
// R26 - Twelve-bit LFSR, x^12+x^6+x^4+x+1, per event
// R27 - Sum truncated to twelve bits
`timescale 1ns/1ps
module dacdc_control
    import dacdc_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger pins, asynchronous
    input wire logic [5:0] timerTrigOut,
    input wire logic extIrqLine9,
    // Converter side
    output logic [1:0] channelOn,
    output logic [1:0] bufferOn,
    output logic [11:0] outputValue0,
    output logic [11:0] outputValue1,
    output logic [1:0] dmaReq
);
    import dacdc_pkg::*;

    logic [31:0] ctl_q;
    logic [1:0] swt_q;
    logic [11:0] hold_q [2];
    logic [11:0] out_q [2];
    logic [11:0] lfsr_q [2];
    logic [11:0] tri_q [2];
    logic [1:0] triDown_q;
    logic [1:0] pend_q;
    logic [6:0] syn1_q, syn2_q, syn3_q;
    logic [1:0] dma_q;

    // Width field to twelve-bit mask of field plus one bits
    function automatic logic [11:0] widthMask(input logic [3:0] w);
        logic [3:0] n;
        n = (w >= NWID_MAX) ? NWID_MAX : w; // R12
        widthMask = ~12'(13'h1FFF << (5'(n) + 5'd1));
    endfunction

    function automatic logic [11:0] lfsrNext(input logic [11:0] s);
        lfsrNext = {s[10:0], s[11] ^ s[5] ^ s[3] ^ s[0]}; // R26
    endfunction

    wire apbWr = psel && penable && pwrite && clkEn;
    wire apbRd = psel && !penable && !pwrite;
    wire known = (paddr[1:0] == 2'b00) && (paddr <= ADDR_DUAL);
    wire [31:0] ctlWrite = pwdata & CTL_MASK;

    // Decoded writes per channel and dual
    wire [1:0] wrR12 = {apbWr && paddr == ADDR_R12_1, apbWr && paddr == ADDR_R12_0};
    wire [1:0] wrL12 = {apbWr && paddr == ADDR_L12_1, apbWr && paddr == ADDR_L12_0};
    wire [1:0] wrR8 = {apbWr && paddr == ADDR_R8_1, apbWr && paddr == ADDR_R8_0};
    wire wrDR12 = apbWr && paddr == ADDR_DR12;
    wire wrDL12 = apbWr && paddr == ADDR_DL12;
    wire wrDR8 = apbWr && paddr == ADDR_DR8;
    wire wrDual = wrDR12 || wrDL12 || wrDR8;

    // Trigger synchronisers: six timers then line 9
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            syn1_q <= 7'h00;
            syn2_q <= 7'h00;
            syn3_q <= 7'h00;
        end
        else if (clkEn)
        begin
            syn1_q <= {extIrqLine9, timerTrigOut};
            syn2_q <= syn1_q;
            syn3_q <= syn2_q;
        end
    end
    wire [6:0] hwRise = syn2_q & ~syn3_q; // R05

    logic [1:0] chOn, ten, dmaOn, hwEv, swEv, trig, upd;
    logic [2:0] sel [2];
    logic [1:0] kind [2];
    logic [3:0] nwid [2];
    logic [11:0] newHold [2];
    logic [11:0] noise [2];
    logic [11:0] nextOut [2];
    logic [11:0] triMax [2];

    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            chOn[c] = ctl_q[c*CH1_SHIFT + F_ON]; // R01
            ten[c] = ctl_q[c*CH1_SHIFT + F_TEN];
            dmaOn[c] = ctl_q[c*CH1_SHIFT + F_DMA];
            sel[c] = ctl_q[c*CH1_SHIFT + F_TSEL +: 3]; // R06
            kind[c] = ctl_q[c*CH1_SHIFT + F_NKIND +: 2]; // R22
            nwid[c] = ctl_q[c*CH1_SHIFT + F_NWID +: 4];
            hwEv[c] = ten[c] && sel[c] != SEL_SOFT && hwRise[sel[c]]; // R06
            swEv[c] = ten[c] && sel[c] == SEL_SOFT && swt_q[c]; // R07
            trig[c] = chOn[c] && (hwEv[c] || swEv[c]); // R08
            // Data forms collapse into one hold value
            newHold[c] = hold_q[c]; // R03
            if (wrR12[c])
                newHold[c] = pwdata[11:0]; // R24
            else if (wrL12[c])
                newHold[c] = pwdata[15:4]; // R24
            else if (wrR8[c])
                newHold[c] = {pwdata[7:0], 4'h0}; // R04
            else if (wrDR12)
                newHold[c] = pwdata[c*16 +: 12]; // R19
            else if (wrDL12)
                newHold[c] = pwdata[c*16 + 4 +: 12]; // R19
            else if (wrDR8)
                newHold[c] = {pwdata[c*8 +: 8], 4'h0}; // R19
            // Untriggered channel follows its hold on the next edge
            upd[c] = chOn[c] && (ten[c] ? trig[c] : (pend_q[c])); // R09
            triMax[c] = widthMask(nwid[c]); // R15
            noise[c] = 12'h000;
            if (ten[c] && kind[c] == NOISE_LFSR) // R11
                noise[c] = lfsr_q[c] & widthMask(nwid[c]); // R14
            else if (ten[c] && kind[c][1]) // R10
                noise[c] = tri_q[c];
            nextOut[c] = 12'(hold_q[c] + noise[c]); // R27
        end
    end

    // Control and soft trigger registers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctl_q <= CTL_RESET;
            swt_q <= 2'b00;
        end
        else if (clkEn)
        begin
            if (apbWr && paddr == ADDR_CTL)
                ctl_q <= ctlWrite;
            for (int c = 0; c < 2; c++)
            begin
                if (apbWr && paddr == ADDR_SWT && pwdata[c])
                    swt_q[c] <= 1'b1; // R07
                else if (swEv[c] && chOn[c])
                    swt_q[c] <= 1'b0; // R25
            end
        end
    end

    // Hold, output, noise state per channel
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend_q <= 2'b00;
            triDown_q <= 2'b00;
            dma_q <= 2'b00;
            for (int c = 0; c < 2; c++)
            begin
                hold_q[c] <= 12'h000;
                out_q[c] <= 12'h000;
                lfsr_q[c] <= LFSR_SEED;
                tri_q[c] <= 12'h000;
            end
        end
        else if (clkEn)
        begin
            for (int c = 0; c < 2; c++)
            begin
                hold_q[c] <= newHold[c];
                pend_q[c] <= wrR12[c] || wrL12[c] || wrR8[c] || wrDual; // R18
                dma_q[c] <= hwEv[c] && dmaOn[c] && chOn[c]; // R16 R17
                if (upd[c])
                    out_q[c] <= nextOut[c]; // R13
                if (trig[c])
                begin
                    lfsr_q[c] <= lfsrNext(lfsr_q[c]); // R26
                    if (kind[c][1])
                    begin
                        if (!triDown_q[c] && tri_q[c] >= triMax[c])
                        begin
                            triDown_q[c] <= 1'b1;
                            tri_q[c] <= 12'(tri_q[c] - 12'h001);
                        end
                        else if (triDown_q[c] && tri_q[c] == 12'h000)
                        begin
                            triDown_q[c] <= 1'b0;
                            tri_q[c] <= 12'h001;
                        end
                        else if (triDown_q[c])
                            tri_q[c] <= 12'(tri_q[c] - 12'h001);
                        else
                            tri_q[c] <= 12'(tri_q[c] + 12'h001); // R15
                    end
                end
            end
        end
    end

    // APB read data, registered in the setup cycle
    logic [31:0] rdMux;
    always_comb
    begin
        case (paddr)
            ADDR_CTL: rdMux = ctl_q;
            ADDR_SWT: rdMux = {30'h0, swt_q};
            ADDR_R12_0: rdMux = {20'h0, hold_q[0]};
            ADDR_R12_1: rdMux = {20'h0, hold_q[1]};
            ADDR_DO0: rdMux = {20'h0, out_q[0]};
            ADDR_DO1: rdMux = {20'h0, out_q[1]};
            ADDR_DUAL: rdMux = {4'h0, out_q[1], 4'h0, out_q[0]};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h0000_0000;
        else if (clkEn && apbRd)
            prdata <= rdMux;
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !known;
    assign channelOn = {ctl_q[CH1_SHIFT + F_ON], ctl_q[F_ON]}; // R01
    assign bufferOn = ~{ctl_q[CH1_SHIFT + F_BOFF], ctl_q[F_BOFF]}; // R02
    assign outputValue0 = out_q[0];
    assign outputValue1 = out_q[1];
    assign dmaReq = dma_q;

    property p_r8zero;
        @(posedge sys_clk) disable iff (!arst_n)
        (clkEn && wrR8[0]) |=> (hold_q[0][3:0] == 4'h0);
    endproperty
    a_r8zero: assert property (p_r8zero) else $error("low hold bits not zero"); // R04

    property p_untrig;
        @(posedge sys_clk) disable iff (!arst_n)
        (clkEn && wrR12[0] && chOn[0] && !ten[0]) ##1 (clkEn && !ten[0] && chOn[0])
        |=> (out_q[0] == $past(hold_q[0]));
    endproperty
    a_untrig: assert property (p_untrig) else $error("output did not follow hold"); // R09

    property p_trigOnly;
        @(posedge sys_clk) disable iff (!arst_n)
        (clkEn && ten[0] && !trig[0]) |=> $stable(out_q[0]);
    endproperty
    a_trigOnly: assert property (p_trigOnly) else $error("output moved without trigger"); // R08

    property p_dmaSoft;
        @(posedge sys_clk) disable iff (!arst_n)
        (sel[0] == SEL_SOFT && $stable(sel[0])) |-> !dmaReq[0];
    endproperty
    a_dmaSoft: assert property (p_dmaSoft) else $error("dma on soft trigger"); // R17

    property p_dmaEn;
        @(posedge sys_clk) disable iff (!arst_n)
        dmaReq[1] |-> $past(dmaOn[1] && ten[1]);
    endproperty
    a_dmaEn: assert property (p_dmaEn) else $error("dma without enables"); // R16

    property p_swClr;
        @(posedge sys_clk) disable iff (!arst_n)
        (clkEn && swEv[1] && chOn[1] && !(apbWr && paddr == ADDR_SWT)) |=> !swt_q[1];
    endproperty
    a_swClr: assert property (p_swClr) else $error("soft trigger not cleared"); // R25

    property p_noNoise;
        @(posedge sys_clk) disable iff (!arst_n)
        (clkEn && upd[0] && kind[0] == NOISE_NONE) |=> out_q[0] == $past(hold_q[0]);
    endproperty
    a_noNoise: assert property (p_noNoise) else $error("noise added in none mode"); // R10

    property p_lfsrMask;
        @(posedge sys_clk) disable iff (!arst_n)
        (nwid[0] == 4'h0 && kind[0] == NOISE_LFSR) |-> noise[0][11:1] == 11'h000;
    endproperty
    a_lfsrMask: assert property (p_lfsrMask) else $error("lfsr noise not masked"); // R14

    property p_dualHold;
        @(posedge sys_clk) disable iff (!arst_n)
        (clkEn && wrDR12) |=> (hold_q[0] == $past(pwdata[11:0]))
            && (hold_q[1] == $past(pwdata[27:16]));
    endproperty
    a_dualHold: assert property (p_dualHold) else $error("dual write missed"); // R19

    property p_buf;
        @(posedge sys_clk) disable iff (!arst_n)
        bufferOn[0] == !ctl_q[F_BOFF];
    endproperty
    a_buf: assert property (p_buf) else $error("buffer state wrong"); // R02

    property p_r12;
        @(posedge sys_clk) disable iff (!arst_n)
        wrR12[0] |=> (hold_q[0] == $past(pwdata[11:0]));
    endproperty
    a_r12: assert property (p_r12) else $error("right12 field misplaced"); // R24

    // Untriggered dual write must land on both outputs at one edge
    property p_dualOut;
        @(posedge sys_clk) disable iff (!arst_n)
        (wrDual && chOn == 2'b11 && ten == 2'b00) ##1 clkEn
        |=> (out_q[0] == $past(hold_q[0])) && (out_q[1] == $past(hold_q[1]));
    endproperty
    a_dualOut: assert property (p_dualOut) else $error("dual outputs not together"); // R18

    property p_freeze;
        @(posedge sys_clk) disable iff (!arst_n)
        !clkEn |=> $stable(ctl_q) && $stable(hold_q[0]) && $stable(out_q[0]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

// ---- bench/dacdc_trig_model.sv ----
// Timer and interrupt-line trigger sources facing the converter
`timescale 1ns/1ps
module dacdc_trig_model
(
    // Clock
    input wire logic sys_clk,
    // Command from the bench
    input wire logic fire,
    input wire logic [2:0] fireCode,
    // Trigger lines
    output logic [5:0] timerTrigOut,
    output logic extIrqLine9
);
    logic [6:0] lines = 7'h00;
    int hold = 0;
    // Held several cycles so the synchroniser cannot miss the edge
    always @(posedge sys_clk)
    begin
        if (fire)
        begin
            lines <= 7'h01 << fireCode;
            hold <= 4;
        end
        else if (hold > 0)
            hold <= hold - 1;
        else
            lines <= 7'h00;
    end
    assign timerTrigOut = lines[5:0];
    assign extIrqLine9 = lines[6];
endmodule

// ---- bench/dacdc_control_bench.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module dacdc_control_bench;
    import dacdc_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] timerTrigOut;
    logic extIrqLine9;
    logic [1:0] channelOn;
    logic [1:0] bufferOn;
    logic [11:0] outputValue0;
    logic [11:0] outputValue1;
    logic [1:0] dmaReq;
    logic clkEn = 1'b1;
    logic fire = 1'b0;
    logic [2:0] fireCode = 3'h0;
    logic [31:0] rd;
    logic err;
    logic [11:0] prev;
    logic [11:0] fAddr [3] = '{ADDR_R12_0, ADDR_L12_0, ADDR_R8_0};
    logic [31:0] fData [3] = '{32'h0000_F123, 32'h0000_ABCD, 32'h0000_015A};
    logic [11:0] fExp [3] = '{12'h123, 12'hABC, 12'h5A0};
    logic [11:0] dAddr [3] = '{ADDR_DR12, ADDR_DL12, ADDR_DR8};
    logic [31:0] dData [3] = '{32'h0ABC_0123, 32'hDEF0_4560, 32'h0000_7A5B};
    logic [23:0] dExp [3] = '{24'hABC_123, 24'hDEF_456, 24'h7A0_5B0};
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int dmaSeen = 0;
    int mark = 0;
    int dmaSeen1 = 0;
    int mark1 = 0;

    always #2 sys_clk = ~sys_clk;

    dacdc_control DUT (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerTrigOut(timerTrigOut),
        .extIrqLine9(extIrqLine9), .channelOn(channelOn), .bufferOn(bufferOn),
        .outputValue0(outputValue0), .outputValue1(outputValue1), .dmaReq(dmaReq));

    dacdc_trig_model timers (.sys_clk(sys_clk), .fire(fire), .fireCode(fireCode),
        .timerTrigOut(timerTrigOut), .extIrqLine9(extIrqLine9));

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Cycle ceiling and counts of channel 0 and channel 1 transfer requests
    always @(posedge sys_clk)
    begin
        cycles++;
        if (dmaReq[0] === 1'b1)
            dmaSeen++;
        if (dmaReq[1] === 1'b1)
            dmaSeen1++;
        if (cycles == 5000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One transfer; entered and left just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic pulse(input logic [2:0] code);
        fireCode <= code;
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (10) @(posedge sys_clk);
    endtask

    function automatic logic [31:0] cfg(input logic ten, input logic [2:0] sel,
        input logic [1:0] kind, input logic [3:0] wid, input logic dma);
        return {19'h0, dma, wid, kind, sel, ten, 1'b0, 1'b1};
    endfunction

    initial
    begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        chk(bufferOn, 2'b11);
        chk(channelOn, 2'b00);
        // Pins are taken as already analog before the first enable
        wr(ADDR_CTL, 32'h0000_0003);
        chk(channelOn, 2'b01);
        chk(bufferOn, 2'b10);
        wr(ADDR_CTL, 32'h0000_0001);
        for (int i = 0; i < 3; i++)
        begin
            wr(fAddr[i], fData[i]);
            repeat (2) @(posedge sys_clk);
            chk(outputValue0, fExp[i]);
        end
        wr(ADDR_CTL, cfg(1'b1, SEL_SOFT, NOISE_NONE, 4'h0, 1'b1));
        wr(ADDR_R12_0, 32'h0000_0456);
        mark = dmaSeen;
        repeat (4) @(posedge sys_clk);
        chk(outputValue0, 12'h5A0);
        wr(ADDR_SWT, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk(outputValue0, 12'h456);
        apb(1'b0, ADDR_SWT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(dmaSeen, mark);
        prev = 12'h456;
        for (int c = 0; c < 7; c++)
        begin
            wr(ADDR_CTL, cfg(1'b1, 3'(c), NOISE_NONE, 4'h0, 1'b1));
            wr(ADDR_R12_0, 32'h0000_0100 + 32'(c));
            pulse(3'((c + 1) % 7));
            chk(outputValue0, prev);
            pulse(3'(c));
            prev = 12'h100 + 12'(c);
            chk(outputValue0, prev);
        end
        chk(dmaSeen, mark + 7);
        wr(ADDR_CTL, cfg(1'b1, 3'h0, NOISE_NONE, 4'h0, 1'b0));
        pulse(3'h0);
        chk(dmaSeen, mark + 7);
        // Triangle of width two ramps 0..3 on successive triggers
        wr(ADDR_CTL, cfg(1'b1, SEL_SOFT, 2'b10, 4'h1, 1'b0));
        wr(ADDR_R12_0, 32'h0000_0200);
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDR_SWT, 32'h0000_0001);
            repeat (2) @(posedge sys_clk);
            chk(outputValue0, 12'h200 + 12'(k));
        end
        // LFSR state is unknown here, so only the width mask is judged
        wr(ADDR_CTL, cfg(1'b1, SEL_SOFT, NOISE_LFSR, 4'h0, 1'b0));
        wr(ADDR_R12_0, 32'h0000_0300);
        wr(ADDR_SWT, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk({outputValue0[11:1], 1'b0}, 12'h300);
        wr(ADDR_CTL, 32'h0001_0001);
        for (int i = 0; i < 3; i++)
        begin
            wr(dAddr[i], dData[i]);
            repeat (2) @(posedge sys_clk);
            chk({outputValue1, outputValue0}, dExp[i]);
        end
        // A write while the clock enable is low is lost
        clkEn <= 1'b0;
        wr(ADDR_R12_0, 32'h0000_0777);
        clkEn <= 1'b1;
        apb(1'b0, ADDR_R12_0, 32'h0000_0000);
        chk(rd, 32'h0000_05B0);
        chk(outputValue0, 12'h5B0);
        // Both channels on one soft trigger
        wr(ADDR_CTL, (cfg(1'b1, SEL_SOFT, NOISE_NONE, 4'h0, 1'b0) << 16)
            | cfg(1'b1, SEL_SOFT, NOISE_NONE, 4'h0, 1'b0));
        wr(ADDR_DL12, 32'h1230_4560);
        chk({outputValue1, outputValue0}, 24'h7A0_5B0);
        wr(ADDR_SWT, 32'h0000_0003);
        repeat (2) @(posedge sys_clk);
        chk({outputValue1, outputValue0}, 24'h123_456);
        apb(1'b0, ADDR_SWT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // Both channels on one timer edge; only channel 1 asks for transfers
        wr(ADDR_CTL, (cfg(1'b1, 3'h2, NOISE_NONE, 4'h0, 1'b1) << 16)
            | cfg(1'b1, 3'h2, NOISE_NONE, 4'h0, 1'b0));
        wr(ADDR_DR12, 32'h0321_0654);
        mark1 = dmaSeen1;
        pulse(3'h2);
        chk({outputValue1, outputValue0}, 24'h321_654);
        chk(dmaSeen1, mark1 + 1);
        chk(dmaSeen, mark + 7);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        test_done();
    end
endmodule
